// file: aas_alu.sv
// aas_alu: 8-bit alu, working accumulator and status register
// assumes the decoder supplies one request per cycle and the file
// datapath returns file_rdata for file_addr in the same cycle
`timescale 1ns/10ps
`default_nettype none

module aas_alu
  import aas_pkg::*;
(
  // clock and reset (power-on and brown-out combined externally)
  input wire logic clock,
  input wire logic rst_n,
  // decoder request
  input wire aas_req_s req,
  input wire aas_evt_s evt,
  // file register datapath
  input wire logic [7:0] file_rdata,
  output logic file_we_ff,
  output logic [6:0] file_waddr_ff,
  output logic [7:0] file_wdata_ff,
  // state views
  output logic [7:0] acc_ff,
  output logic [7:0] status_ff,
  output logic sram_page_select_ff
);

  // ========================================================
  // operand selection
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] file_val;

  function automatic logic hits_status(input logic [6:0] addr);
    hits_status = (addr == STATUS_ADDR);
  endfunction

  // the status register is served here, not from the file datapath
  assign file_val = hits_status(req.file_addr) ? status_ff : file_rdata;

  always_comb begin
    opb = req.b_imm ? req.imm : file_val;
    opa = acc_ff;
    if (req.src_file && (req.op inside {AAS_OP_PASS, AAS_OP_COM,
        AAS_OP_INC, AAS_OP_DEC, AAS_OP_RLC, AAS_OP_RRC, AAS_OP_SWAP})) begin
      opa = file_val;
    end
  end

  // ========================================================
  // arithmetic
  function automatic logic [8:0] add9(input logic [7:0] a,
      input logic [7:0] b, input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  function automatic logic [4:0] add5(input logic [3:0] a,
      input logic [3:0] b, input logic cin);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  logic [7:0] res;
  logic res_c;
  logic res_dc;
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    res = opa;
    res_c = status_ff[BIT_CARRY];
    res_dc = status_ff[BIT_NIBBLE];
    sum = 9'h000;
    nib = 5'h00;
    unique case (req.op)
      AAS_OP_ADD: begin
        sum = add9(opb, opa, 1'b0);
        nib = add5(opb[3:0], opa[3:0], 1'b0);
        res = sum[7:0];
        res_c = sum[8];
        res_dc = nib[4];
      end
      AAS_OP_SUB: begin
        // file minus acc via two's complement: carry out means no borrow
        sum = add9(opb, ~opa, 1'b1);
        nib = add5(opb[3:0], ~opa[3:0], 1'b1);
        res = sum[7:0];
        res_c = sum[8];
        res_dc = nib[4];
      end
      AAS_OP_AND: res = opa & opb;
      AAS_OP_OR: res = opa | opb;
      AAS_OP_XOR: res = opa ^ opb;
      AAS_OP_COM: res = ~opa;
      AAS_OP_INC: res = opa + 8'h01;
      AAS_OP_DEC: res = opa - 8'h01;
      AAS_OP_RLC: begin
        res = {opa[6:0], status_ff[BIT_CARRY]};
        res_c = opa[7];
      end
      AAS_OP_RRC: begin
        res = {status_ff[BIT_CARRY], opa[7:1]};
        res_c = opa[0];
      end
      AAS_OP_SWAP: res = {opa[3:0], opa[7:4]};
      AAS_OP_CLR: res = 8'h00;
      AAS_OP_PASS: res = req.b_imm ? req.imm : opa;
      default: res = opa;
    endcase
  end

  // ========================================================
  // flag update mask and new values
  logic [7:0] flag_mask;
  logic [7:0] flag_val;

  always_comb begin
    flag_mask = 8'h00;
    if (req.valid) begin
      unique case (req.flags)
        AAS_FL_NONE: flag_mask = 8'h00;
        AAS_FL_Z: flag_mask = ZERO_ONLY_MASK;
        AAS_FL_C: flag_mask = 8'h01;
        AAS_FL_CDZ: flag_mask = ARITH_MASK;
      endcase
    end
    flag_val = 8'h00;
    flag_val[BIT_CARRY] = res_c;
    flag_val[BIT_NIBBLE] = res_dc;
    flag_val[BIT_ZERO] = (res == 8'h00);
  end

  logic to_status;
  assign to_status = req.valid && req.dest_file &&
      hits_status(req.file_addr);

  // ========================================================
  // status register
  logic [7:0] nxt_status;
  logic [7:0] wr_mask;

  always_comb begin
    // a flag-affecting op locks all three arithmetic bits, not only its own
    wr_mask = WRITABLE_MASK;
    if (req.flags != AAS_FL_NONE) begin
      wr_mask = WRITABLE_MASK & ~ARITH_MASK;
    end
    nxt_status = status_ff;
    if (to_status) begin
      nxt_status = (status_ff & ~wr_mask) | (res & wr_mask);
    end
    // results win over the written value for affected flags
    nxt_status = (nxt_status & ~flag_mask) | (flag_val & flag_mask);
    if (evt.wdog_kick || evt.sleep) begin
      nxt_status[BIT_WDOG] = 1'b0;
    end
    if (evt.wdog_expired) begin
      nxt_status[BIT_WDOG] = 1'b1;
    end
    if (evt.wdog_kick) begin
      nxt_status[BIT_SLEEP] = 1'b0;
    end
    if (evt.sleep) begin
      nxt_status[BIT_SLEEP] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sram_page_select_ff <= 1'b0;
    end else begin
      sram_page_select_ff <= nxt_status[BIT_PAGE];
    end
  end

  // ========================================================
  // accumulator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 8'h00;
    end else if (req.valid && !req.dest_file) begin
      acc_ff <= res;
    end
  end

  // ========================================================
  // file write-back (status writes stay local)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      file_we_ff <= 1'b0;
      file_waddr_ff <= 7'h00;
      file_wdata_ff <= 8'h00;
    end else begin
      file_we_ff <= req.valid && req.dest_file && !to_status;
      file_waddr_ff <= req.file_addr;
      file_wdata_ff <= res;
    end
  end

  // ========================================================
  // checks
  // the add and subtract expectations are rebuilt from the operands rather
  // than from add9 and add5, so a broken adder cannot agree with itself
  sequence seq_add_cdz;
    req.valid && req.op == AAS_OP_ADD && req.flags == AAS_FL_CDZ;
  endsequence

  sequence seq_sub_cdz;
    req.valid && req.op == AAS_OP_SUB && req.flags == AAS_FL_CDZ;
  endsequence

  sequence seq_quiet_events;
    !evt.wdog_expired && !evt.wdog_kick && !evt.sleep;
  endsequence

  chk_add_carry: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_add_cdz |=> status_ff[BIT_CARRY] ==
    ($past({1'b0, opa} + {1'b0, opb}) > 9'h0ff))
    else $error("add carry wrong");

  chk_add_nibble: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_add_cdz |=> status_ff[BIT_NIBBLE] ==
    ($past({1'b0, opa[3:0]} + {1'b0, opb[3:0]}) > 5'h0f))
    else $error("add nibble carry wrong");

  chk_add_result: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.valid && req.op == AAS_OP_ADD && !req.dest_file
    |=> acc_ff == $past(opa + opb))
    else $error("add result wrong");

  chk_sub_borrow: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_sub_cdz |=> status_ff[BIT_CARRY] == ($past(opb) >= $past(opa)) &&
    status_ff[BIT_NIBBLE] == ($past(opb[3:0]) >= $past(opa[3:0])))
    else $error("subtract borrow flags wrong");

  chk_sub_result: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.valid && req.op == AAS_OP_SUB && !req.dest_file
    |=> acc_ff == $past(opb - opa))
    else $error("subtract result wrong");

  chk_zero_flag: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.valid && (req.flags inside {AAS_FL_Z, AAS_FL_CDZ})
    |=> status_ff[BIT_ZERO] == ($past(res) == 8'h00))
    else $error("zero flag wrong");

  chk_rotate_carry: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.valid && (req.op inside {AAS_OP_RLC, AAS_OP_RRC}) &&
    req.flags == AAS_FL_C |=> status_ff[BIT_CARRY] ==
    $past((req.op == AAS_OP_RLC) ? opa[7] : opa[0]))
    else $error("rotate carry wrong");

  chk_no_flag_op: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.valid && req.flags == AAS_FL_NONE && !to_status &&
    !evt.wdog_expired && !evt.wdog_kick && !evt.sleep
    |=> $stable(status_ff))
    else $error("status changed by flag-free op");

  chk_acc_private: assert property (
    @(posedge clock) disable iff (!rst_n)
    !req.valid || req.dest_file |=> $stable(acc_ff))
    else $error("accumulator changed without an acc result");

  chk_file_wb: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.valid && req.dest_file && !to_status |=> file_we_ff &&
    file_wdata_ff == $past(res) &&
    file_waddr_ff == $past(req.file_addr))
    else $error("file write-back wrong");

  chk_status_local: assert property (
    @(posedge clock) disable iff (!rst_n)
    to_status || !req.valid |=> !file_we_ff)
    else $error("status write leaked to file datapath");

  chk_wdog_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    evt.wdog_expired |=> status_ff[BIT_WDOG])
    else $error("watchdog flag not set");

  chk_kick_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    evt.wdog_kick && !evt.wdog_expired && !evt.sleep
    |=> !status_ff[BIT_WDOG] && !status_ff[BIT_SLEEP])
    else $error("kick did not clear flags");

  chk_sleep_flags: assert property (
    @(posedge clock) disable iff (!rst_n)
    evt.sleep && !evt.wdog_expired
    |=> status_ff[BIT_SLEEP] && !status_ff[BIT_WDOG])
    else $error("sleep flags wrong");

  chk_ro_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_quiet_events |=> $stable(status_ff[BIT_WDOG]) &&
    $stable(status_ff[BIT_SLEEP]))
    else $error("read-only bits changed");

  chk_spare_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    to_status && req.op == AAS_OP_PASS
    |=> status_ff[7:5] == $past(res[7:5]) &&
    sram_page_select_ff == status_ff[BIT_PAGE])
    else $error("status write of storage bits lost");

  chk_page_copy: assert property (
    @(posedge clock) disable iff (!rst_n)
    sram_page_select_ff == status_ff[BIT_PAGE])
    else $error("page select differs from status bit");

  chk_flag_guard: assert property (
    @(posedge clock) disable iff (!rst_n)
    to_status && req.flags == AAS_FL_CDZ
    |=> status_ff[2:0] == $past(flag_val[2:0]))
    else $error("status write overrode flags");

  chk_zonly_guard: assert property (
    @(posedge clock) disable iff (!rst_n)
    to_status && req.flags == AAS_FL_Z
    |=> status_ff[BIT_CARRY] == $past(status_ff[BIT_CARRY]) &&
    status_ff[BIT_NIBBLE] == $past(status_ff[BIT_NIBBLE]))
    else $error("status write touched locked flags");

endmodule // aas_alu

`default_nettype wire

// file: aas_file_model.sv
// aas_file_model: file register space behind the alu
// assumes 7-bit addresses and a combinational read port
`timescale 1ns/10ps
`default_nettype none
module aas_file_model (
  // clock
  input wire logic clock,
  // read side
  input wire logic [6:0] addr,
  output logic [7:0] rdata,
  // write side
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  // ==========================================================
  // storage
  // seeded with a pattern so a missed write shows up
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'h3c ^ 8'(i);
  always @(posedge clock) begin
    if (we) mem[waddr] <= wdata;
  end
  assign rdata = mem[addr];
endmodule // aas_file_model
`default_nettype wire

// file: aas_pkg.sv
// aas_pkg: constants and carriers for the alu / accumulator / status block
// assumes one 8-bit datapath clocked by the core clock
package aas_pkg;

  // ==========================================================
  // widths and addresses
  localparam int unsigned DATA_W = 8;
  localparam logic [6:0] STATUS_ADDR = 7'h03;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ==========================================================
  // status bit positions
  localparam int unsigned BIT_CARRY = 0;
  localparam int unsigned BIT_NIBBLE = 1;
  localparam int unsigned BIT_ZERO = 2;
  localparam int unsigned BIT_SLEEP = 3;
  localparam int unsigned BIT_WDOG = 4;
  localparam int unsigned BIT_PAGE = 5;
  localparam int unsigned BIT_SPARE1 = 6;
  localparam int unsigned BIT_SPARE0 = 7;
  localparam logic [7:0] ARITH_MASK = 8'h07;
  localparam logic [7:0] ZERO_ONLY_MASK = 8'h04;
  localparam logic [7:0] WRITABLE_MASK = 8'he7;

  // ==========================================================
  // operations
  typedef enum logic [3:0] {
    AAS_OP_PASS,
    AAS_OP_ADD,
    AAS_OP_SUB,
    AAS_OP_AND,
    AAS_OP_OR,
    AAS_OP_XOR,
    AAS_OP_COM,
    AAS_OP_INC,
    AAS_OP_DEC,
    AAS_OP_RLC,
    AAS_OP_RRC,
    AAS_OP_SWAP,
    AAS_OP_CLR
  } aas_op_e;

  // which flags an operation updates
  typedef enum logic [1:0] {
    AAS_FL_NONE,
    AAS_FL_Z,
    AAS_FL_C,
    AAS_FL_CDZ
  } aas_flags_e;

  // one instruction's worth of ALU work from the decoder
  typedef struct packed {
    logic valid;
    aas_op_e op;
    aas_flags_e flags;
    logic src_file;
    logic b_imm;
    logic [7:0] imm;
    logic dest_file;
    logic [6:0] file_addr;
  } aas_req_s;

  // system events affecting the status bits
  typedef struct packed {
    logic wdog_expired;
    logic wdog_kick;
    logic sleep;
  } aas_evt_s;

endpackage

// file: alu_accumulator_status_flags_tb.sv
// alu_accumulator_status_flags_tb: self-checking bench for aas_alu
// assumes aas_file_model stands in for the file datapath
`timescale 1ns/10ps
`default_nettype none
module alu_accumulator_status_flags_tb
  import aas_pkg::*;
;
  // ==========================================================
  // signals
  typedef struct {
    aas_op_e op;
    aas_flags_e fl;
    logic cin;
    logic [7:0] a, b, res, st, msk;
  } aas_row_s;
  logic clock, rst_n, we;
  aas_req_s req;
  aas_evt_s evt;
  logic [7:0] rdata, wdata, acc, st;
  logic [6:0] waddr;
  logic page;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  aas_row_s rows [16] = '{
    '{AAS_OP_ADD, AAS_FL_CDZ, 0, 8'hff, 8'h01, 8'h00, 8'h07, 8'h07},
    '{AAS_OP_ADD, AAS_FL_CDZ, 0, 8'h08, 8'h08, 8'h10, 8'h02, 8'h07},
    '{AAS_OP_ADD, AAS_FL_CDZ, 0, 8'h10, 8'h20, 8'h30, 8'h00, 8'h07},
    '{AAS_OP_SUB, AAS_FL_CDZ, 0, 8'h01, 8'h10, 8'h0f, 8'h01, 8'h07},
    '{AAS_OP_SUB, AAS_FL_CDZ, 0, 8'h02, 8'h01, 8'hff, 8'h00, 8'h07},
    '{AAS_OP_SUB, AAS_FL_CDZ, 0, 8'h05, 8'h05, 8'h00, 8'h07, 8'h07},
    '{AAS_OP_AND, AAS_FL_Z, 0, 8'hf0, 8'h0f, 8'h00, 8'h04, 8'h04},
    '{AAS_OP_OR, AAS_FL_Z, 0, 8'hf0, 8'h0f, 8'hff, 8'h00, 8'h04},
    '{AAS_OP_XOR, AAS_FL_Z, 0, 8'haa, 8'haa, 8'h00, 8'h04, 8'h04},
    '{AAS_OP_COM, AAS_FL_Z, 0, 8'h55, 8'h00, 8'haa, 8'h00, 8'h04},
    '{AAS_OP_INC, AAS_FL_Z, 0, 8'hff, 8'h00, 8'h00, 8'h04, 8'h04},
    '{AAS_OP_DEC, AAS_FL_Z, 0, 8'h01, 8'h00, 8'h00, 8'h04, 8'h04},
    '{AAS_OP_RLC, AAS_FL_C, 1, 8'h80, 8'h00, 8'h01, 8'h01, 8'h01},
    '{AAS_OP_RRC, AAS_FL_C, 1, 8'h02, 8'h00, 8'h81, 8'h00, 8'h01},
    '{AAS_OP_SWAP, AAS_FL_NONE, 0, 8'h12, 8'h00, 8'h21, 8'h00, 8'h00},
    '{AAS_OP_CLR, AAS_FL_Z, 0, 8'h12, 8'h00, 8'h00, 8'h04, 8'h04}
  };

  aas_alu u_dut (.clock(clock), .rst_n(rst_n), .req(req), .evt(evt),
    .file_rdata(rdata), .file_we_ff(we), .file_waddr_ff(waddr),
    .file_wdata_ff(wdata), .acc_ff(acc), .status_ff(st),
    .sram_page_select_ff(page));
  aas_file_model u_file (.clock(clock), .addr(req.file_addr),
    .rdata(rdata), .we(we), .waddr(waddr), .wdata(wdata));

  // ==========================================================
  // clock, timeout and tasks
  initial clock = 1'b0;
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request, valid for exactly one edge
  task automatic run(input aas_op_e op, input aas_flags_e fl,
                     input logic sf, bi, input logic [7:0] imm,
                     input logic df, input logic [6:0] ad);
    @(posedge clock);
    #1 req = '{1'b1, op, fl, sf, bi, imm, df, ad};
    @(posedge clock);
    #1 req.valid = 1'b0;
  endtask
  task automatic wst(input logic [7:0] v);
    run(AAS_OP_PASS, AAS_FL_NONE, 0, 1, v, 1, STATUS_ADDR);
  endtask
  task automatic ld(input logic [7:0] v);
    run(AAS_OP_PASS, AAS_FL_NONE, 0, 1, v, 0, 7'h00);
  endtask
  task automatic ev(input aas_evt_s e, input logic [7:0] x);
    @(posedge clock);
    #1 evt = e;
    @(posedge clock);
    #1 evt = '0;
    chk("status events", x, st & 8'h18);
  endtask

  // ==========================================================
  // sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    evt = '0;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    chk("status reset", STATUS_RESET, st);
    chk("acc reset", 8'h00, acc);
    foreach (rows[i]) begin
      wst({7'h00, rows[i].cin});
      ld(rows[i].a);
      run(rows[i].op, rows[i].fl, 0, 1, rows[i].b, 0, 7'h00);
      chk("acc", rows[i].res, acc);
      chk("flags", rows[i].st & rows[i].msk, st & rows[i].msk);
      $display("row %0d done", i);
    end
    wst(8'hff);
    chk("status write", 8'he7, st);
    chk("no file write", 8'h00, {7'h0, we});
    chk("page", 8'h01, {7'h0, page});
    ld(8'h21);
    wst(8'h00);
    run(AAS_OP_ADD, AAS_FL_CDZ, 0, 1, 8'hff, 1, STATUS_ADDR);
    chk("flag write yields", 8'h23, st);
    wst(8'h03);
    run(AAS_OP_AND, AAS_FL_Z, 0, 1, 8'h00, 1, STATUS_ADDR);
    chk("z-only status write", 8'h07, st);
    $display("status tests done");
    run(AAS_OP_PASS, AAS_FL_NONE, 0, 1, 8'h9c, 1, 7'h20);
    chk("file write", 8'h9c, we ? wdata : 8'hxx);
    ld(8'h04);
    run(AAS_OP_ADD, AAS_FL_CDZ, 0, 0, 8'h00, 0, 7'h20);
    chk("file operand", 8'ha0, acc);
    run(AAS_OP_INC, AAS_FL_Z, 1, 0, 8'h00, 1, 7'h20);
    chk("single file op", 8'h9d, we ? wdata : 8'hxx);
    chk("write addr", 8'h20, {1'b0, waddr});
    wst(8'hc0);
    run(AAS_OP_PASS, AAS_FL_NONE, 1, 0, 8'h00, 0, STATUS_ADDR);
    chk("status read", 8'hc0, acc);
    $display("file tests done");
    ev('{1'b1, 1'b0, 1'b0}, 8'h10);
    ev('{1'b0, 1'b0, 1'b1}, 8'h08);
    ev('{1'b1, 1'b0, 1'b0}, 8'h18);
    ev('{1'b0, 1'b1, 1'b0}, 8'h00);
    ev('{1'b1, 1'b1, 1'b0}, 8'h10);
    $display("event tests done");
    #1 rst_n = 1'b0;
    #2 chk("mid reset", 8'h00, st);
    chk("acc mid reset", 8'h00, acc);
    @(posedge clock);
    #1 rst_n = 1'b1;
    ld(8'h5a);
    chk("acc after reset", 8'h5a, acc);
    $display("reset tests done");
    print_verdict();
  end
endmodule // alu_accumulator_status_flags_tb
`default_nettype wire
